// [design/uam_pkg.sv]
// Package for the serial port mode, interrupt mask and status block.
// Assumes a 32-bit APB register bus with word-aligned byte offsets.
package uam_pkg;

  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_IENSET = 8'h08;
  localparam logic [7:0] OFS_IENCLR = 8'h0C;
  localparam logic [7:0] OFS_IMASK  = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;

  // Control command bits
  localparam int unsigned CB_RX_RST   = 2;
  localparam int unsigned CB_TX_RST   = 3;
  localparam int unsigned CB_RX_EN    = 4;
  localparam int unsigned CB_RX_DIS   = 5;
  localparam int unsigned CB_TX_EN    = 6;
  localparam int unsigned CB_TX_DIS   = 7;
  localparam int unsigned CB_CLR_ERR  = 8;

  // Mode fields
  localparam int unsigned MODE_PAR_LSB = 9;
  localparam int unsigned MODE_CHM_LSB = 14;
  localparam logic [31:0] MODE_MASK    = 32'h0000_CE00;
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;

  // Shared bit layout of enable, disable, mask and status
  localparam int unsigned SB_RECEIVE_CHAR_WAITING  = 0;
  localparam int unsigned SB_TRANSMIT_HOLDING_FREE  = 1;
  localparam int unsigned SB_RECEIVE_DMA_DONE  = 3;
  localparam int unsigned SB_TRANSMIT_DMA_DONE  = 4;
  localparam int unsigned SB_OVR    = 5;
  localparam int unsigned SB_FRM    = 6;
  localparam int unsigned SB_PAR    = 7;
  localparam int unsigned SB_TXEMP  = 9;
  localparam int unsigned SB_TRANSMIT_DMA_BUFFER_EMPTY = 11;
  localparam int unsigned SB_RECEIVE_DMA_BUFFER_FULL = 12;
  localparam logic [31:0] IRQ_MASK  = 32'h0000_1AFB;
  localparam logic [31:0] IMR_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    PAR_EVEN, PAR_ODD, PAR_SPACE, PAR_MARK, PAR_NONE
  } uam_par_t;

  typedef enum logic [1:0] {
    CHM_NORMAL, CHM_ECHO, CHM_LOCAL, CHM_REMOTE
  } uam_chm_t;

  // Events and levels from the shifting engines
  typedef struct packed {
    logic rx_load;    // Character moved into receive holding reg
    logic rx_read;    // Receive holding reg read by software
    logic overrun;
    logic frame_err;
    logic parity_err;
    logic tx_full;    // Transmit holding reg holds a character
    logic tx_busy;    // Shift register active
  } uam_eng_t;

  // Levels from the peripheral DMA channels
  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic tx_buf_empty;
    logic rx_buf_full;
  } uam_dma_t;

endpackage

// [design/uam_top.sv]
// Mode, interrupt mask and status logic of a two-wire serial port.
// Assumes an APB master on pclk and shifting engines on the same clock
// that report character events as one-cycle pulses.
// Operation
// RULE_01: Parity field picks even, odd, forced 0, forced 1 or no parity.
// RULE_02: Channel field at bits 15:14 picks normal, echo, local or remote loop.
// RULE_03: Writing enable-set register sets mask bits written as 1.
// RULE_04: Writing enable-clear register clears mask bits written as 1.
// RULE_05: Reading mask register returns current mask, 1 meaning enabled.
// RULE_06: Enable, disable, mask and status share one fixed bit layout.
// RULE_07: Receive-ready sets when a character lands in the holding register.
// RULE_08: Receive-ready clears on holding read and reads 0 while receiver off.
// RULE_09: Transmit-ready is 0 while holding full or transmitter off, else 1.
// RULE_10: Transmitter-idle is 1 only with nothing held or shifting and enabled.
// RULE_11: Overrun flag is sticky until the clear-errors command.
// RULE_12: Framing flag is sticky until the clear-errors command.
// RULE_13: Parity-error flag is sticky until the clear-errors command.
// RULE_14: Receive DMA done flag mirrors the receive channel end signal.
// RULE_15: Transmit DMA done flag mirrors the transmit channel end signal.
// RULE_16: Transmit buffer empty flag mirrors the transmit channel signal.
// RULE_17: Receive buffer full flag mirrors the receive channel signal.
// RULE_18: Control write with clear-errors bit clears parity, framing, overrun.
// RULE_19: Echo mode retransmits the input pin; transmitter output ignored.
// RULE_20: Local loop feeds transmitter to receiver; output pin held high.
// RULE_21: Remote loop ties input pin to output; engines disabled.
// RULE_22: Interrupt request is high when any flag and its mask bit are 1.
// RULE_23: Reserved bits read 0 and writes to them are ignored.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps

module uam_top
  import uam_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              pclk,          // APB clock
  input  wire logic              presetn,       // Async reset, active low
  input  wire logic              psel,          // APB select
  input  wire logic              penable,       // APB access phase
  input  wire logic              pwrite,        // APB direction
  input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
  input  wire logic [31:0]       pwdata,        // APB write data
  output logic [31:0]            prdata,        // APB read data
  output logic                   pready,        // APB ready
  output logic                   pslverr,       // APB error, unmapped
  input  wire uam_eng_t          eng,           // Engine events and levels
  input  wire uam_dma_t          dma,           // DMA channel levels
  input  wire logic              serial_in_pin, // Receive line pin
  output logic                   serial_out_pin,// Transmit line pin
  input  wire logic              tx_line,       // Transmitter shift output
  output logic                   rx_line,       // Line seen by receiver
  output logic                   rx_enable,     // Receiver may run
  output logic                   tx_enable,     // Transmitter may run
  output logic                   rx_reset,      // Receiver reset pulse
  output logic                   tx_reset,      // Transmitter reset pulse
  output uam_par_t               check_bit_type,// Parity selection
  output uam_chm_t               channel_test_select, // Channel mode
  output logic                   irq            // Interrupt request
);

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("ADDR_W must be 8 to 32");
    end
  end

  logic [31:0] mode_r;
  logic [31:0] imr_r;
  logic        receive_char_waiting_r;
  logic        ovr_r;
  logic        frm_r;
  logic        par_r;
  logic        rx_en_r;
  logic        tx_en_r;
  logic        rx_reset_r;
  logic        tx_reset_r;
  logic        irq_r;
  logic        serial_out_r;
  logic        rx_line_r;
  logic [31:0] prdata_r;
  logic [31:0] status;
  logic        wr_acc;
  logic        setup;
  logic        hit;
  logic [7:0]  ofs;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        wr_set;
  logic        wr_clr;
  logic        clr_err;
  logic        remote;
  logic        rx_on;
  logic        tx_on;
  uam_chm_t    chm;

  assign ofs    = paddr[7:0];
  assign hit    = (paddr[ADDR_W-1:8] == '0) && (ofs[1:0] == 2'b00)
                  && (ofs <= OFS_STAT);
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && hit;
  assign wr_ctrl = wr_acc && (ofs == OFS_CTRL);
  assign wr_mode = wr_acc && (ofs == OFS_MODE);
  assign wr_set  = wr_acc && (ofs == OFS_IENSET);
  assign wr_clr  = wr_acc && (ofs == OFS_IENCLR);
  assign clr_err = wr_ctrl && pwdata[CB_CLR_ERR];

  // Zero wait states keep the master simple; errors only for holes
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_r;

  // Mode register, reserved bits dropped on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RESET;
    end else if (wr_mode) begin
      mode_r <= pwdata & MODE_MASK;                     // see RULE_23
    end
  end

  assign chm = uam_chm_t'(mode_r[MODE_CHM_LSB +: 2]);  // see RULE_02
  assign check_bit_type = uam_par_t'(mode_r[MODE_PAR_LSB +: 3]); // see RULE_01
  assign channel_test_select = chm;
  assign remote = (chm == CHM_REMOTE);

  // Interrupt mask; a same-cycle set and clear cannot occur on one bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imr_r <= IMR_RESET;
    end else if (wr_set) begin
      imr_r <= imr_r | (pwdata & IRQ_MASK);             // see RULE_03
    end else if (wr_clr) begin
      imr_r <= imr_r & ~(pwdata & IRQ_MASK);            // see RULE_04
    end
  end

  // Engine enables; enable wins only when its disable and reset bits are 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (pwdata[CB_RX_RST] || pwdata[CB_RX_DIS]) begin
        rx_en_r <= 1'b0;
      end else if (pwdata[CB_RX_EN]) begin
        rx_en_r <= 1'b1;
      end
      if (pwdata[CB_TX_RST] || pwdata[CB_TX_DIS]) begin
        tx_en_r <= 1'b0;
      end else if (pwdata[CB_TX_EN]) begin
        tx_en_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_reset_r <= 1'b0;
      tx_reset_r <= 1'b0;
    end else begin
      rx_reset_r <= wr_ctrl && pwdata[CB_RX_RST];
      tx_reset_r <= wr_ctrl && pwdata[CB_TX_RST];
    end
  end

  // Remote loop takes both engines out of service
  assign rx_on     = rx_en_r && !remote;                 // see RULE_21
  assign tx_on     = tx_en_r && !remote;                 // see RULE_21
  assign rx_enable = rx_on;
  assign tx_enable = tx_on;
  assign rx_reset  = rx_reset_r;
  assign tx_reset  = tx_reset_r;

  // Receive ready: a new character wins over a same-cycle read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_char_waiting_r <= 1'b0;
    end else if (eng.rx_load) begin
      receive_char_waiting_r <= 1'b1;                                   // see RULE_07
    end else if (eng.rx_read || rx_reset_r) begin
      receive_char_waiting_r <= 1'b0;                                   // see RULE_08
    end
  end

  // Sticky errors; an error in the clearing cycle stays recorded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_r <= 1'b0;
      frm_r <= 1'b0;
      par_r <= 1'b0;
    end else begin
      ovr_r <= eng.overrun    || (ovr_r && !clr_err);   // see RULE_11 RULE_18
      frm_r <= eng.frame_err  || (frm_r && !clr_err);   // see RULE_12 RULE_18
      par_r <= eng.parity_err || (par_r && !clr_err);   // see RULE_13 RULE_18
    end
  end

  // Status word in the shared layout, reserved bits zero
  always_comb begin
    status            = '0;                             // see RULE_23
    status[SB_RECEIVE_CHAR_WAITING]  = receive_char_waiting_r && rx_on;               // see RULE_08
    status[SB_TRANSMIT_HOLDING_FREE]  = tx_on && !eng.tx_full;          // see RULE_09
    status[SB_RECEIVE_DMA_DONE]  = dma.rx_done;                    // see RULE_14
    status[SB_TRANSMIT_DMA_DONE]  = dma.tx_done;                    // see RULE_15
    status[SB_OVR]    = ovr_r;
    status[SB_FRM]    = frm_r;
    status[SB_PAR]    = par_r;
    status[SB_TXEMP]  = tx_on && !eng.tx_full && !eng.tx_busy; // see RULE_10
    status[SB_TRANSMIT_DMA_BUFFER_EMPTY] = dma.tx_buf_empty;               // see RULE_16
    status[SB_RECEIVE_DMA_BUFFER_FULL] = dma.rx_buf_full;                // see RULE_17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status & imr_r);                       // see RULE_22 RULE_06
    end
  end
  assign irq = irq_r;

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup) begin
      unique case (ofs)
        OFS_MODE:  prdata_r <= mode_r;
        OFS_IMASK: prdata_r <= imr_r;                   // see RULE_05
        OFS_STAT:  prdata_r <= status;                  // see RULE_06
        default:   prdata_r <= '0;
      endcase
    end
  end

  // Pin routing per channel mode; one flop of latency on each path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_r <= 1'b1;
      rx_line_r    <= 1'b1;
    end else begin
      unique case (chm)
        CHM_NORMAL: begin
          serial_out_r <= tx_line;
          rx_line_r    <= serial_in_pin;
        end
        CHM_ECHO: begin
          serial_out_r <= serial_in_pin;                 // see RULE_19
          rx_line_r    <= serial_in_pin;
        end
        CHM_LOCAL: begin
          serial_out_r <= 1'b1;                          // see RULE_20
          rx_line_r    <= tx_line;
        end
        CHM_REMOTE: begin
          serial_out_r <= serial_in_pin;                 // see RULE_21
          rx_line_r    <= 1'b1;
        end
      endcase
    end
  end
  assign serial_out_pin = serial_out_r;
  assign rx_line        = rx_line_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MASK_SET: assert property (                       // see RULE_03
    wr_set |=> ((imr_r & $past(pwdata) & IRQ_MASK) == ($past(pwdata) & IRQ_MASK))
      && ((imr_r & ~$past(pwdata)) == ($past(imr_r) & ~$past(pwdata))))
    else $error("mask set write wrong");

  AST_MASK_CLR: assert property (                       // see RULE_04
    wr_clr |=> ((imr_r & $past(pwdata)) == '0)
      && ((imr_r & ~$past(pwdata)) == ($past(imr_r) & ~$past(pwdata))))
    else $error("mask clear write wrong");

  AST_MASK_READ: assert property (                      // see RULE_05
    (setup && ofs == OFS_IMASK) |=> (prdata == $past(imr_r)))
    else $error("mask read wrong");

  AST_RECEIVE_CHAR_WAITING_SET: assert property (                      // see RULE_07
    (eng.rx_load && rx_on && !wr_ctrl && !wr_mode) |=> status[SB_RECEIVE_CHAR_WAITING])
    else $error("receive ready not set");

  AST_RECEIVE_CHAR_WAITING_OFF: assert property (                      // see RULE_08
    !rx_on |-> !status[SB_RECEIVE_CHAR_WAITING])
    else $error("receive ready while receiver off");

  AST_TRANSMIT_HOLDING_FREE: assert property (                          // see RULE_09
    status[SB_TRANSMIT_HOLDING_FREE] == (tx_en_r && !remote && !eng.tx_full))
    else $error("transmit ready wrong");

  AST_TXEMP: assert property (                          // see RULE_10
    status[SB_TXEMP] |-> (status[SB_TRANSMIT_HOLDING_FREE] && !eng.tx_busy))
    else $error("transmitter idle wrong");

  AST_ERR_STICKY: assert property (                     // see RULE_11
    (ovr_r && !clr_err) |=> ovr_r)
    else $error("overrun flag dropped");

  AST_ERR_CLEAR: assert property (                      // see RULE_18
    (clr_err && !eng.overrun && !eng.frame_err && !eng.parity_err)
      |=> !ovr_r && !frm_r && !par_r)
    else $error("clear errors failed");

  AST_FRM_SET: assert property (                        // see RULE_12
    eng.frame_err |=> frm_r)
    else $error("framing flag not set");

  AST_PAR_SET: assert property (                        // see RULE_13
    eng.parity_err |=> par_r)
    else $error("parity flag not set");

  AST_DMA: assert property (                            // see RULE_14
    status[SB_RECEIVE_DMA_DONE] == dma.rx_done && status[SB_TRANSMIT_DMA_DONE] == dma.tx_done
      && status[SB_RECEIVE_DMA_BUFFER_FULL] == dma.rx_buf_full
      && status[SB_TRANSMIT_DMA_BUFFER_EMPTY] == dma.tx_buf_empty)            // see RULE_16 RULE_17
    else $error("dma mirror wrong");

  AST_IRQ: assert property (                            // see RULE_22
    ##1 irq == |($past(status) & $past(imr_r)))
    else $error("interrupt request wrong");

  AST_LOCAL: assert property (                          // see RULE_20
    (chm == CHM_LOCAL) [*2] |-> serial_out_pin && rx_line == $past(tx_line))
    else $error("local loop routing wrong");

  AST_ECHO: assert property (                           // see RULE_19
    (chm == CHM_ECHO) [*2] |-> serial_out_pin == $past(serial_in_pin))
    else $error("echo routing wrong");

  AST_RSVD: assert property (                           // see RULE_23
    (mode_r & ~MODE_MASK) == '0 && (imr_r & ~IRQ_MASK) == '0)
    else $error("reserved bits set");

  COV_IRQ:    cover property (wr_set ##[1:20] irq);
  COV_CLR:    cover property (ovr_r ##1 clr_err ##1 !ovr_r);
  COV_REMOTE: cover property (wr_mode ##1 remote);
  COV_RECEIVE_CHAR_WAITING:  cover property (eng.rx_load ##[1:20] eng.rx_read);

endmodule // uam_top

// [tb/uam_line_partner.sv]
// Remote serial device: sends one frame per request on the receive line.
// Assumes one bit per pclk cycle; the line rests high between frames.
`timescale 1ns/100ps

module uam_line_partner (
  input  wire logic       pclk,    // Bench clock
  input  wire logic       presetn, // Async reset, active low
  input  wire logic       go,      // Start a frame
  input  wire logic [7:0] chr,     // Character to send
  output logic            line,    // Receive pin of the block
  output logic            busy     // Frame in progress
);
  logic [9:0] sh_r;
  logic [3:0] cnt_r;

  // Start bit 0, data LSB first, stop bit 1, then idle high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r  <= 10'h3FF;
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'h0) begin
      sh_r  <= {1'b1, sh_r[9:1]};
      cnt_r <= cnt_r - 4'h1;
    end else if (go) begin
      sh_r  <= {1'b1, chr, 1'b0};
      cnt_r <= 4'hA;
    end
  end
  assign line = sh_r[0];
  assign busy = (cnt_r != 4'h0);
endmodule // uam_line_partner

// [tb/uam_top_tb_top.sv]
// Self-checking bench for the mode, mask and status block.
// Assumes a zero-wait APB slave and one-cycle engine event pulses.
`timescale 1ns/100ps

module uam_top_tb_top;
  import uam_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, tx_line, go, pin_chk, p_in, p_tx;
  logic        rx_en, tx_en, receive_char_waiting, ovr, frm, perr, pready, pslverr, irq, s_out, s_in;
  logic        rx_line, rx_enable, tx_enable, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, mask, r, v;
  logic [6:0]  eng_v;
  logic [3:0]  dma_v;
  logic [7:0]  chr;
  logic [1:0]  chm;
  uam_par_t    par_o;
  uam_chm_t    chm_o;
  logic [33:0] exp_q[$];
  int          bad_count, n_checks, cyc;

  uam_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng(uam_eng_t'(eng_v)), .dma(uam_dma_t'(dma_v)),
    .serial_in_pin(s_in), .serial_out_pin(s_out), .tx_line(tx_line), .rx_line(rx_line),
    .rx_enable(rx_enable), .tx_enable(tx_enable), .rx_reset(), .tx_reset(),
    .check_bit_type(par_o), .channel_test_select(chm_o), .irq(irq));
  uam_line_partner PTR (.pclk(pclk), .presetn(presetn), .go(go), .chr(chr),
    .line(s_in), .busy(busy));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [31:0] exp_stat();
    logic [31:0] s;
    s = 32'h0;
    s[SB_RECEIVE_CHAR_WAITING] = receive_char_waiting & rx_en;
    s[SB_TRANSMIT_HOLDING_FREE] = tx_en & !eng_v[1];
    s[SB_TXEMP] = tx_en & !eng_v[1] & !eng_v[0];
    {s[SB_RECEIVE_DMA_DONE], s[SB_TRANSMIT_DMA_DONE], s[SB_TRANSMIT_DMA_BUFFER_EMPTY], s[SB_RECEIVE_DMA_BUFFER_FULL]} = dma_v;
    {s[SB_OVR], s[SB_FRM], s[SB_PAR]} = {ovr, frm, perr};
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    exp_q.push_back({w, ee, ed});
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, {4'h0, a}, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, {4'h0, a}, 32'h0, e, 1'b0);
  endtask

  task automatic ev(input logic [6:0] m);
    @(posedge pclk);
    eng_v <= eng_v | m;
    @(posedge pclk);
    eng_v <= eng_v & ~m;
  endtask

  task automatic tend(input string nm);
    $display("test %s done, checks %0d", nm, n_checks);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Read data and error are judged at the edge that completes the access
  always @(posedge pclk) begin
    logic [33:0] e;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (!e[33]) chk(prdata, e[31:0]);
      chk({31'h0, pslverr}, {31'h0, e[32]});
    end
  end

  // Pin routing lags its inputs by one cycle
  always @(posedge pclk) begin
    if (pin_chk) chk({30'h0, s_out, rx_line}, {30'h0, (chm == 2'h0) ? p_tx : (chm == 2'h2) ?
      1'b1 : p_in, (chm == 2'h2) ? p_tx : (chm == 2'h3) ? 1'b1 : p_in});
    p_in = s_in;
    p_tx = tx_line;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    {psel, penable, pwrite, tx_line, go, pin_chk, rx_en, tx_en, receive_char_waiting, ovr, frm, perr} = '0;
    {paddr, pwdata, eng_v, dma_v, chr, chm, mask} = '0;
    seed = 32'd99584;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_MODE, MODE_RESET);
    rd(OFS_IMASK, IMR_RESET);
    rd(OFS_STAT, exp_stat());
    tend("reset");
    wr(OFS_CTRL, 32'h0000_0050);
    rx_en = 1'b1;
    tx_en = 1'b1;
    for (int p = 0; p < 5; p++) begin
      for (int c = 0; c < 4; c++) begin
        r = rnd();
        v = {16'h0, c[1:0], 2'h0, p[2:0], 9'h0} | (r & ~MODE_MASK);
        wr(OFS_MODE, v);
        rd(OFS_MODE, v & MODE_MASK);
        chk({27'h0, par_o, chm_o}, {27'h0, p[2:0], c[1:0]});
        chk({30'h0, rx_enable, tx_enable}, {30'h0, {2{c != 3}}});
        chm = c[1:0];
        chr = r[15:8];
        go <= 1'b1;
        pin_chk <= 1'b1;
        repeat (14) begin
          @(posedge pclk);
          r = rnd();
          go <= 1'b0;
          tx_line <= r[0];
        end
        pin_chk <= 1'b0;
      end
    end
    wr(OFS_MODE, 32'h0);
    tend("mode and pins");
    rd(OFS_STAT, exp_stat());
    for (int i = 1; i < 4; i++) begin
      @(posedge pclk);
      eng_v <= {5'h0, i[1:0]};
      @(posedge pclk);
      rd(OFS_STAT, exp_stat());
    end
    ev(7'h40);
    receive_char_waiting = 1'b1;
    rd(OFS_STAT, exp_stat());
    ev(7'h20);
    receive_char_waiting = 1'b0;
    rd(OFS_STAT, exp_stat());
    ev(7'h40);
    receive_char_waiting = 1'b1;
    wr(OFS_CTRL, 32'h0000_0020);
    rx_en = 1'b0;
    rd(OFS_STAT, exp_stat());
    tend("ready flags");
    ev(7'h10);
    ovr = 1'b1;
    rd(OFS_STAT, exp_stat());
    ev(7'h08);
    frm = 1'b1;
    ev(7'h04);
    perr = 1'b1;
    ev(7'h10);
    rd(OFS_STAT, exp_stat());
    wr(OFS_CTRL, 32'h0000_0100);
    {ovr, frm, perr} = 3'h0;
    rd(OFS_STAT, exp_stat());
    tend("error flags");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      @(posedge pclk);
      dma_v <= r[3:0];
      // Always let an edge pass so the new DMA levels settle before expecting them
      ev(i[0] ? (r[6:4] << 2) : 7'h00);
      {ovr, frm, perr} = {ovr, frm, perr} | (i[0] ? r[6:4] : 3'h0);
      rd(OFS_STAT, exp_stat());
      wr(OFS_IENSET, r);
      mask = mask | (r & IRQ_MASK);
      rd(OFS_IMASK, mask);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, |(exp_stat() & mask)});
      r = rnd();
      wr(OFS_IENCLR, r);
      mask = mask & ~r;
      rd(OFS_IMASK, mask);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, |(exp_stat() & mask)});
    end
    tend("mask and dma");
    wr(OFS_STAT, 32'hFFFF_FFFF);
    wr(OFS_IMASK, 32'hFFFF_FFFF);
    rd(OFS_IMASK, mask);
    apb(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h106, 32'hFFFF_FFFF, 32'h0, 1'b1);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_MODE, 32'h0);
    tend("access");
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule // uam_top_tb_top
